/* File: inc/bfl_pkg.sv */
/*
 * bfl_pkg: constants and types shared by the breaker failure logic.
 * assumes a 125 MHz system clock; all delays are in milliseconds.
 */
`default_nettype none
package bfl_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_FREQ_HZ = 125000000;
	localparam int TICK_PERIOD_US = 1000;
	localparam int TICK_CYCLES = CLK_FREQ_HZ / 1000000 * TICK_PERIOD_US;
	localparam int TICK_CNT_W = 17;

	// ----------------------------------------------------------------
	// setting ranges and defaults, milliseconds
	// ----------------------------------------------------------------
	localparam int MS_W = 16;
	localparam logic [MS_W-1:0] RETRIP_MS_MIN = 16'h0000;
	localparam logic [MS_W-1:0] RETRIP_MS_MAX = 16'h03e8;
	localparam logic [MS_W-1:0] RETRIP_MS_RST = 16'h0064;
	localparam logic [MS_W-1:0] BACKUP_MS_MIN = 16'h0064;
	localparam logic [MS_W-1:0] BACKUP_MS_MAX = 16'hea60;
	localparam logic [MS_W-1:0] BACKUP_MS_RST = 16'h03e8;
	localparam logic [MS_W-1:0] PULSE_MS_MIN = 16'h0000;
	localparam logic [MS_W-1:0] PULSE_MS_MAX = 16'hea60;
	localparam logic [MS_W-1:0] PULSE_MS_RST = 16'h0064;

	// ----------------------------------------------------------------
	// operating mode
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		BFL_MODE_OFF     = 2'b00,
		BFL_MODE_CURRENT = 2'b01,
		BFL_MODE_CONTACT = 2'b10,
		BFL_MODE_BOTH    = 2'b11
	} bfl_mode_e;

	// phase channels 0..2, residual channel 3
	localparam int NCH = 4;
	localparam int CH_RES = 3;

	// clamp a setting into its range
	function automatic logic [MS_W-1:0] bfl_clamp(input logic [MS_W-1:0] v,
		input logic [MS_W-1:0] lo, input logic [MS_W-1:0] hi);
		logic [MS_W-1:0] r;
		r = v;
		if (v < lo) begin
			r = lo;
		end else if (v > hi) begin
			r = hi;
		end
		return r;
	endfunction

endpackage
`default_nettype wire

/* File: logic/bfl_ms_timer.sv */
/*
 * bfl_ms_timer: one millisecond delay timer, armed by a start pulse.
 * assumes tick is a one-cycle enable once per millisecond on sys_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module bfl_ms_timer
	import bfl_pkg::*;
(
	input  wire logic            sys_clk,
	input  wire logic            rst_n,
	input  wire logic            sync_clr,
	input  wire logic            tick,
	input  wire logic            start,
	input  wire logic            stop,
	input  wire logic [MS_W-1:0] delay_ms,
	output logic                 running,
	output logic                 expired
);
	logic            run_r;
	logic            run_nxt;
	logic [MS_W-1:0] cnt_r;
	logic [MS_W-1:0] cnt_nxt;

	// ------------------------------------------------------------
	// count down; zero delay expires on the first cycle after start
	// ------------------------------------------------------------
	always_comb begin
		run_nxt = run_r;
		cnt_nxt = cnt_r;
		expired = 1'b0;
		if (sync_clr || stop) begin
			run_nxt = 1'b0;
		end else if (start) begin
			run_nxt = 1'b1;
			cnt_nxt = delay_ms;
		end else if (run_r) begin
			if (cnt_r == '0) begin
				expired = 1'b1;
				run_nxt = 1'b0;
			end else if (tick) begin
				cnt_nxt = cnt_r - 16'h0001;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_r <= 1'b0;
			cnt_r <= '0;
		end else begin
			run_r <= run_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign running = run_r;
endmodule
`default_nettype wire

/* File: logic/bfl_core.sv */
/*
 * bfl_core: breaker failure decision logic, common or single-pole variant.
 * assumes all inputs come from protection logic on sys_clk, except the
 * breaker contact inputs and block, which are synchronised here.
 */
// Notes on behaviour
// - timers start on start rising edge only
// - per phase: separate backup and retrip timers
// - supervise current, contact or both while running
// - current mode ignores breaker contact inputs
// - contact mode ignores current flags
// - single-pole: three contacts; common: one contact
// - combined mode resets only when all healthy
// - mode off: no trips, timers idle
// - backup expiry with failure raises backup trip
// - trip held at least pulse duration
// - retrip per failing phase when enabled
// - block input suppresses trips dynamically
// - four flags: three phase, one residual
// - retrip outputs only in single-pole variant
// - retrip delay 0..1000 ms, default 100
// - backup delay 100..60000 ms, default 1000
// - pulse duration 0..60000 ms, default 100
`timescale 1ns/1ns
`default_nettype none
module bfl_core
	import bfl_pkg::*;
(
	input  wire logic            sys_clk,
	input  wire logic            rst_n,
	input  wire logic            sync_clr,
	input  wire logic            single_pole,
	input  wire bfl_pkg::bfl_mode_e mode,
	input  wire logic            retrip_en,
	input  wire logic [MS_W-1:0] retrip_ms,
	input  wire logic [MS_W-1:0] backup_ms,
	input  wire logic [MS_W-1:0] pulse_ms,
	input  wire logic            function_block_in,
	input  wire logic            general_start_in,
	input  wire logic            start_ph1_in,
	input  wire logic            start_ph2_in,
	input  wire logic            start_ph3_in,
	input  wire logic            residual_start_in,
	input  wire logic            over_current_ph1,
	input  wire logic            over_current_ph2,
	input  wire logic            over_current_ph3,
	input  wire logic            over_current_res,
	input  wire logic            breaker_closed_in,
	input  wire logic            breaker_closed_ph1_in,
	input  wire logic            breaker_closed_ph2_in,
	input  wire logic            breaker_closed_ph3_in,
	output logic                 backup_trip_out,
	output logic                 retrip_ph1_out,
	output logic                 retrip_ph2_out,
	output logic                 retrip_ph3_out,
	output logic                 busy_out
);
	// ------------------------------------------------------------
	// pin synchronisers for contacts and block
	// ------------------------------------------------------------
	logic [4:0] pin_s1_r;
	logic [4:0] pin_s2_r;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
		end else begin
			pin_s1_r <= {function_block_in, breaker_closed_in, breaker_closed_ph3_in,
				breaker_closed_ph2_in, breaker_closed_ph1_in};
			pin_s2_r <= pin_s1_r;
		end
	end

	logic blk;
	logic [2:0] cb_ph;
	logic cb_com;
	assign blk    = pin_s2_r[4];
	assign cb_com = pin_s2_r[3];
	assign cb_ph  = pin_s2_r[2:0];

	// ------------------------------------------------------------
	// millisecond tick divider
	// ------------------------------------------------------------
	logic [TICK_CNT_W-1:0] tick_cnt_r;
	logic [TICK_CNT_W-1:0] tick_cnt_nxt;
	logic                  tick;
	always_comb begin
		tick = (tick_cnt_r == TICK_CNT_W'(TICK_CYCLES - 1));
		tick_cnt_nxt = tick ? '0 : tick_cnt_r + 1'b1;
		if (sync_clr) begin
			tick_cnt_nxt = '0;
		end
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_r <= '0;
		end else begin
			tick_cnt_r <= tick_cnt_nxt;
		end
	end

	// ------------------------------------------------------------
	// settings clamped to range
	// ------------------------------------------------------------
	logic [MS_W-1:0] rt_ms;
	logic [MS_W-1:0] bu_ms;
	logic [MS_W-1:0] pl_ms;
	assign rt_ms = bfl_clamp(retrip_ms, RETRIP_MS_MIN, RETRIP_MS_MAX);
	assign bu_ms = bfl_clamp(backup_ms, BACKUP_MS_MIN, BACKUP_MS_MAX);
	assign pl_ms = bfl_clamp(pulse_ms, PULSE_MS_MIN, PULSE_MS_MAX);

	// ------------------------------------------------------------
	// start requests per channel and edge detect
	// ------------------------------------------------------------
	logic [NCH-1:0] st_lvl;
	logic [NCH-1:0] st_prev_r;
	logic [NCH-1:0] st_rise;
	logic           enabled;
	assign enabled = (mode != BFL_MODE_OFF);
	always_comb begin
		// common variant: general start feeds every phase channel
		if (single_pole) begin
			st_lvl[2:0] = {start_ph3_in, start_ph2_in, start_ph1_in} |
				{3{general_start_in}};
		end else begin
			st_lvl[2:0] = {3{general_start_in}};
		end
		st_lvl[CH_RES] = residual_start_in;
		st_rise = st_lvl & ~st_prev_r & {NCH{enabled}};
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_prev_r <= '0;
		end else if (sync_clr) begin
			st_prev_r <= '0;
		end else begin
			st_prev_r <= st_lvl;
		end
	end

	// ------------------------------------------------------------
	// supervision: failure indication per channel
	// ------------------------------------------------------------
	logic [NCH-1:0] cur_fail;
	logic [NCH-1:0] cb_fail;
	logic [NCH-1:0] fail;
	always_comb begin
		cur_fail = {over_current_res, over_current_ph3, over_current_ph2,
			over_current_ph1};
		cb_fail[2:0] = single_pole ? cb_ph : {3{cb_com}};
		cb_fail[CH_RES] = single_pole ? |cb_ph : cb_com;
		case (mode)
			BFL_MODE_CURRENT: fail = cur_fail;
			BFL_MODE_CONTACT: fail = cb_fail;
			BFL_MODE_BOTH:    fail = cur_fail | cb_fail;
			default:          fail = '0;
		endcase
	end

	// ------------------------------------------------------------
	// timers: backup per channel, retrip per phase
	// ------------------------------------------------------------
	logic [NCH-1:0] bu_run;
	logic [NCH-1:0] bu_exp;
	logic [2:0]     rt_run;
	logic [2:0]     rt_exp;
	logic           tmr_clr;
	// healthy while running stops the timer; both mode needs all healthy
	assign tmr_clr = sync_clr || !enabled;
	for (genvar i = 0; i < NCH; i++) begin : g_bu
		bfl_ms_timer u_bu (
			.sys_clk  (sys_clk),
			.rst_n    (rst_n),
			.sync_clr (tmr_clr),
			.tick     (tick),
			.start    (st_rise[i]),
			.stop     (bu_run[i] && !fail[i] && !st_rise[i]),
			.delay_ms (bu_ms),
			.running  (bu_run[i]),
			.expired  (bu_exp[i])
		);
	end
	for (genvar i = 0; i < 3; i++) begin : g_rt
		bfl_ms_timer u_rt (
			.sys_clk  (sys_clk),
			.rst_n    (rst_n),
			.sync_clr (tmr_clr || !single_pole || !retrip_en),
			.tick     (tick),
			.start    (st_rise[i]),
			.stop     (rt_run[i] && !fail[i] && !st_rise[i]),
			.delay_ms (rt_ms),
			.running  (rt_run[i]),
			.expired  (rt_exp[i])
		);
	end

	// ------------------------------------------------------------
	// trip pulse stretchers: backup plus three retrips
	// ------------------------------------------------------------
	logic [3:0]      trip_req;
	logic [3:0]      trip_keep;
	logic [3:0]      trip_r;
	logic [3:0]      trip_nxt;
	logic [MS_W-1:0] hold_r [4];
	logic [MS_W-1:0] hold_nxt [4];
	logic            suppress;
	assign suppress = blk || !enabled;
	always_comb begin
		trip_req[0] = |(bu_exp & fail);
		trip_req[3:1] = rt_exp & fail[2:0] & {3{single_pole && retrip_en}};
		// backup stays while any channel fails, a retrip while its own phase does
		trip_keep = {fail[2:0], |fail};
		for (int k = 0; k < 4; k++) begin
			trip_nxt[k] = trip_r[k];
			hold_nxt[k] = hold_r[k];
			if (sync_clr || suppress) begin
				trip_nxt[k] = 1'b0;
				hold_nxt[k] = '0;
			end else if (k != 0 && !single_pole) begin
				// a standing retrip must not survive a switch to common variant
				trip_nxt[k] = 1'b0;
				hold_nxt[k] = '0;
			end else if (trip_req[k]) begin
				trip_nxt[k] = 1'b1;
				hold_nxt[k] = pl_ms;
			end else if (trip_r[k]) begin
				// release only after the minimum time and once healthy
				if (hold_r[k] == '0) begin
					trip_nxt[k] = trip_keep[k];
				end else if (tick) begin
					hold_nxt[k] = hold_r[k] - 16'h0001;
				end
			end
		end
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			trip_r <= '0;
			for (int k = 0; k < 4; k++) begin
				hold_r[k] <= '0;
			end
		end else begin
			trip_r <= trip_nxt;
			for (int k = 0; k < 4; k++) begin
				hold_r[k] <= hold_nxt[k];
			end
		end
	end

	assign backup_trip_out = trip_r[0];
	assign retrip_ph1_out  = trip_r[1];
	assign retrip_ph2_out  = trip_r[2];
	assign retrip_ph3_out  = trip_r[3];
	assign busy_out        = |bu_run | |rt_run;
endmodule
`default_nettype wire

/* File: verification/bfl_props.sv */
/* bfl_props: port assertions for bfl_core.
   assumes one clock, rst_n asynchronous active low; bound at the foot. */
`timescale 1ns/1ns
`default_nettype none
module bfl_props
	import bfl_pkg::*;
(
	input wire logic               sys_clk,
	input wire logic               rst_n,
	input wire logic               sync_clr,
	input wire logic               single_pole,
	input wire logic               retrip_en,
	input wire bfl_pkg::bfl_mode_e mode,
	input wire logic               function_block_in,
	input wire logic               general_start_in,
	input wire logic               start_ph1_in,
	input wire logic               start_ph2_in,
	input wire logic               start_ph3_in,
	input wire logic               residual_start_in,
	input wire logic               over_current_ph1,
	input wire logic               over_current_ph2,
	input wire logic               over_current_ph3,
	input wire logic               over_current_res,
	input wire logic               breaker_closed_in,
	input wire logic               breaker_closed_ph1_in,
	input wire logic               breaker_closed_ph2_in,
	input wire logic               breaker_closed_ph3_in,
	input wire logic               backup_trip_out,
	input wire logic               retrip_ph1_out,
	input wire logic               retrip_ph2_out,
	input wire logic               retrip_ph3_out,
	input wire logic               busy_out
);
	logic [4:0] st_v;
	logic [2:0] blk_r;
	logic       oc_any, bc_any, rt_any, calm;
	// summaries; calm means block and clear have been quiet long enough
	assign st_v = {general_start_in, start_ph1_in, start_ph2_in, start_ph3_in, residual_start_in};
	assign oc_any = over_current_ph1 | over_current_ph2 | over_current_ph3 | over_current_res;
	assign bc_any = breaker_closed_in | breaker_closed_ph1_in | breaker_closed_ph2_in
		| breaker_closed_ph3_in;
	assign rt_any = retrip_ph1_out | retrip_ph2_out | retrip_ph3_out;
	assign calm = blk_r == 3'h0 && !function_block_in && !sync_clr;
	// block history, three deep to cover the two-flop synchroniser
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			blk_r <= 3'h0;
		end else begin
			blk_r <= {blk_r[1:0], function_block_in};
		end
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	property p_off; mode == BFL_MODE_OFF [*2] |-> !backup_trip_out && !rt_any && !busy_out; endproperty
	a_off: assert property (p_off) else $error("output active in mode off");
	property p_block; function_block_in [*5] |-> !backup_trip_out && !rt_any; endproperty
	a_block: assert property (p_block) else $error("trip while blocked");
	property p_common; !single_pole [*3] |-> !rt_any; endproperty
	a_common: assert property (p_common) else $error("retrip in common variant");
	property p_arm; $rose(general_start_in) && mode == BFL_MODE_CURRENT && over_current_ph1
		&& calm |=> busy_out; endproperty
	a_arm: assert property (p_arm) else $error("start edge did not arm");
	property p_res; $rose(residual_start_in) && mode == BFL_MODE_CURRENT && over_current_res
		&& calm |=> busy_out; endproperty
	a_res: assert property (p_res) else $error("residual start did not arm");
	property p_cur; (mode == BFL_MODE_CURRENT && !oc_any && $stable(st_v)) [*4] |-> !busy_out;
	endproperty
	a_cur: assert property (p_cur) else $error("contact kept current mode busy");
	property p_con; (mode == BFL_MODE_CONTACT && !bc_any && $stable(st_v)) [*6] |-> !busy_out;
	endproperty
	a_con: assert property (p_con) else $error("flag kept contact mode busy");
	property p_clr; sync_clr |=> !busy_out && !backup_trip_out && !rt_any; endproperty
	a_clr: assert property (p_clr) else $error("clear left state");
	property p_fall; $fell(retrip_ph1_out) && blk_r == 3'h0 && !$past(sync_clr)
		&& $past(retrip_en) && $past(single_pole) && $past(mode) == BFL_MODE_CURRENT
		|-> !$past(over_current_ph1); endproperty
	a_fall: assert property (p_fall) else $error("retrip dropped while failing");
	c_trip: cover property ($rose(retrip_ph1_out));
	c_block: cover property (function_block_in && rt_any);
	c_busy: cover property ($rose(busy_out));
endmodule
bind bfl_core bfl_props bfl_props_inst (.sys_clk, .rst_n, .sync_clr, .single_pole, .retrip_en,
	.mode, .function_block_in, .general_start_in, .start_ph1_in, .start_ph2_in, .start_ph3_in,
	.residual_start_in, .over_current_ph1, .over_current_ph2, .over_current_ph3,
	.over_current_res, .breaker_closed_in, .breaker_closed_ph1_in, .breaker_closed_ph2_in,
	.breaker_closed_ph3_in, .backup_trip_out, .retrip_ph1_out, .retrip_ph2_out,
	.retrip_ph3_out, .busy_out);
`default_nettype wire

/* File: verification/bfl_breaker_model.sv */
/* bfl_breaker_model: breaker contacts seen by bfl_core.
   assumes close commands from the bench; index 3 is the common contact. */
`timescale 1ns/1ns
`default_nettype none
module bfl_breaker_model (
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic [3:0] close_cmd,
	input  wire logic [3:0] trip,
	output logic      [3:0] closed
);
	logic [3:0] trip_r, closed_r;
	// a pole opens only two cycles after its trip lands, as a mechanism lags
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			trip_r <= 4'h0;
			closed_r <= 4'h0;
		end else begin
			trip_r <= trip;
			closed_r <= close_cmd & ~trip_r;
		end
	end
	assign closed = closed_r;
endmodule
`default_nettype wire

/* File: verification/test_breaker_failure_logic.sv */
/* test_breaker_failure_logic: random and corner tests of bfl_core.
   assumes bfl_props is bound in and bfl_breaker_model drives the contacts. */
`timescale 1ns/1ns
`default_nettype none
module test_breaker_failure_logic;
	import bfl_pkg::*;
	logic            sys_clk = 1'b0, rst_n = 1'b0, sync_clr = 1'b0, single_pole = 1'b0;
	logic            retrip_en = 1'b0, function_block_in = 1'b0, general_start_in = 1'b0;
	logic            start_ph1_in = 1'b0, start_ph2_in = 1'b0, start_ph3_in = 1'b0;
	logic            residual_start_in = 1'b0;
	logic [3:0]      oc = 4'h0, cmd = 4'h0;
	bfl_mode_e       mode = BFL_MODE_OFF;
	logic [MS_W-1:0] retrip_ms = 16'h0000, backup_ms = 16'h03e8, pulse_ms = 16'h0000;
	wire logic [3:0] bc;
	logic            backup_trip_out, retrip_ph1_out, retrip_ph2_out, retrip_ph3_out, busy_out;
	logic [31:0]     seed = 32'h5d46a177;
	int              n_errors = 0, tests_run = 0;
	bfl_core bfl_core_inst (.sys_clk, .rst_n, .sync_clr, .single_pole, .mode, .retrip_en,
		.retrip_ms, .backup_ms, .pulse_ms, .function_block_in, .general_start_in,
		.start_ph1_in, .start_ph2_in, .start_ph3_in, .residual_start_in,
		.over_current_ph1(oc[0]), .over_current_ph2(oc[1]), .over_current_ph3(oc[2]),
		.over_current_res(oc[3]), .breaker_closed_in(bc[3]), .breaker_closed_ph1_in(bc[0]),
		.breaker_closed_ph2_in(bc[1]), .breaker_closed_ph3_in(bc[2]), .backup_trip_out,
		.retrip_ph1_out, .retrip_ph2_out, .retrip_ph3_out, .busy_out);
	bfl_breaker_model bfl_breaker_model_inst (.sys_clk, .rst_n, .close_cmd(cmd),
		.trip({backup_trip_out, retrip_ph3_out, retrip_ph2_out, retrip_ph1_out}), .closed(bc));
	always #4 sys_clk = ~sys_clk;
	// inputs move one ns after the edge, never racing the sampling edge
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input string what, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %b seen %b", what, e, g);
		end
	endtask
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	// failure seen by the phase channels under a general start
	function automatic logic fail_exp(input bfl_mode_e m, input logic sp, input logic [3:0] f,
		input logic [3:0] b);
		logic cur, con;
		cur = |f[2:0];
		con = sp ? |b[2:0] : b[3];
		case (m)
			BFL_MODE_CURRENT: return cur;
			BFL_MODE_CONTACT: return con;
			BFL_MODE_BOTH: return cur | con;
			default: return 1'b0;
		endcase
	endfunction
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// main sequence; retrip delay is zero because one real tick is 125000 cycles
	initial begin
		step(10);
		rst_n = 1'b1;
		step(2);
		for (int i = 0; i < 12; i++) begin
			seed = xs(seed);
			mode = bfl_mode_e'(seed[1:0]);
			single_pole = seed[2];
			oc = seed[7:4];
			cmd = seed[11:8];
			backup_ms = seed[31:16];
			if (i < 3) begin
				mode = bfl_mode_e'(i + 1);
				oc = (i == 1) ? 4'hf : 4'h0;
				cmd = (i == 0) ? 4'hf : (i == 2) ? 4'h9 : 4'h0;
			end
			step(5);
			general_start_in = 1'b1;
			step(6);
			chk("busy_out", fail_exp(mode, single_pole, oc, cmd), busy_out);
			general_start_in = 1'b0;
			mode = BFL_MODE_OFF;
			step(2);
		end
		$display("test supervision done");
		mode = BFL_MODE_CURRENT;
		oc = 4'h8;
		residual_start_in = 1'b1;
		step(2);
		chk("busy_out", 1'b1, busy_out);
		sync_clr = 1'b1;
		step(1);
		sync_clr = 1'b0;
		chk("busy_out", 1'b0, busy_out);
		residual_start_in = 1'b0;
		$display("test residual done");
		single_pole = 1'b1;
		retrip_en = 1'b1;
		oc = 4'h3;
		step(2);
		start_ph1_in = 1'b1;
		start_ph2_in = 1'b1;
		for (int k = 0; k < 100 && retrip_ph1_out !== 1'b1; k++) begin
			step(1);
		end
		chk("retrip_ph1_out", 1'b1, retrip_ph1_out);
		chk("retrip_ph2_out", 1'b1, retrip_ph2_out);
		chk("retrip_ph3_out", 1'b0, retrip_ph3_out);
		chk("backup_trip_out", 1'b0, backup_trip_out);
		step(20);
		chk("retrip_ph1_out", 1'b1, retrip_ph1_out);
		oc = 4'h2;
		step(3);
		chk("retrip_ph1_out", 1'b0, retrip_ph1_out);
		chk("retrip_ph2_out", 1'b1, retrip_ph2_out);
		single_pole = 1'b0;
		start_ph2_in = 1'b0;
		step(2);
		chk("retrip_ph2_out", 1'b0, retrip_ph2_out);
		chk("busy_out", 1'b1, busy_out);
		single_pole = 1'b1;
		start_ph2_in = 1'b1;
		step(3);
		chk("retrip_ph2_out", 1'b1, retrip_ph2_out);
		function_block_in = 1'b1;
		step(4);
		chk("retrip_ph2_out", 1'b0, retrip_ph2_out);
		$display("test retrip done");
		finish_test();
	end
	// watchdog at 5000 cycles, far above the few hundred the tests need
	initial begin
		#40000;
		n_errors++;
		finish_test();
	end
endmodule
`default_nettype wire
